// ===== inc/ast_pkg.sv
package ast_pkg;
   localparam int SYS_MHZ     = 50;
   localparam int INT_TB_MHZ  = 40;
   localparam int LIST_DEPTH  = 512;
   localparam int STORE_DEPTH = 4096;

   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_CMD    = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_RESULT = 8'h0c;
   localparam logic [7:0] A_SCAN   = 8'h10;
   localparam logic [7:0] A_SAMP   = 8'h14;
   localparam logic [7:0] A_POST   = 8'h18;
   localparam logic [7:0] A_NCHAN  = 8'h1c;
   localparam logic [7:0] A_PRE_M  = 8'h20;
   localparam logic [7:0] A_DELAY  = 8'h24;
   localparam logic [7:0] A_LIST   = 8'h28;
   localparam logic [7:0] A_STORE  = 8'h2c;
   localparam logic [7:0] A_STCNT  = 8'h30;

   localparam int CMD_CONV  = 0;
   localparam int CMD_START = 1;
   localparam int CMD_TRIG  = 2;
   localparam int CMD_CLEAR = 3;
   localparam int CMD_ABORT = 4;

   localparam logic [23:0] SCAN_RST  = 24'h000280;
   localparam logic [15:0] SAMP_RST  = 16'h00a0;
   localparam logic [23:0] POST_RST  = 24'h000001;
   localparam logic [8:0]  NCHAN_RST = 9'h001;
   localparam logic [15:0] PRE_RST   = 16'h0001;
   localparam logic [15:0] DELAY_RST = 16'h0000;

   typedef enum logic [1:0] {referenced_single_ended,
      nonreferenced_single_ended, differential_input} ast_incfg_t;
   typedef enum logic [1:0] {TM_PRE, TM_POST, TM_MIDDLE,
      TM_DELAY} ast_tmode_t;
   typedef enum logic [1:0] {TS_SOFT, TS_ANALOG, TS_DIGITAL}
      ast_tsrc_t;
   typedef enum logic [2:0] {PH_IDLE, PH_ARMED, PH_DELAY, PH_PRE,
      PH_POST} ast_phase_t;

   typedef struct packed {
      ast_incfg_t cfg;
      logic       bipolar;
      logic [1:0] gain;
      logic [5:0] chan;
   } ast_entry_t;

   typedef struct packed {
      logic [22:0] rsvd;
      logic        trig_fall;
      logic        dly_sample_clk;
      logic        ext_tb;
      logic        guard;
      ast_tsrc_t   src;
      ast_tmode_t  tmode;
      logic        scan_mode;
   } ast_ctrl_t;

   localparam ast_ctrl_t CTRL_RST = 32'h00000000;
endpackage

// ===== hw/ast_sequencer.sv
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module ast_sequencer (
   input  wire logic               sys_clk,
   input  wire logic               arst_n,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               external_pacing_clock_in,
   input  wire logic               ana_trig_in,
   input  wire logic               dig_trig_in,
   input  wire logic               adc_done,
   input  wire logic [15:0]        adc_data,
   output logic                    conv_start,
   output ast_pkg::ast_entry_t     conv_entry,
   output logic                    simultaneous_hold_out
);
   import ast_pkg::*;

   ast_ctrl_t   ctrl;
   ast_phase_t  phase;
   logic [23:0] scan_int;
   logic [15:0] sample_interval_count;
   logic [23:0] post_scan_count;
   logic [8:0]  samples_per_scan_count;
   logic [15:0] pre_m;
   logic [15:0] dly_load;
   logic [15:0] result;
   logic        res_ready;
   logic        ovf;
   logic [5:0]  tb_acc;
   logic        ext_q;
   logic        src_q;
   logic        in_scan;
   logic        stop_pend;
   logic [23:0] si_cnt;
   logic [15:0] si2_cnt;
   logic [9:0]  samp_left;
   logic [9:0]  res_left;
   logic [23:0] post_left;
   logic [15:0] pre_scans;
   logic [15:0] dly_cnt;
   logic [15:0] sclk_div;
   logic [8:0]  list_rd;
   logic [8:0]  fire_idx;
   logic [9:0]  list_len;
   logic [11:0] wr_ptr;
   logic [11:0] rd_ptr;
   logic [12:0] st_cnt;
   ast_entry_t  list_mem [LIST_DEPTH];
   logic [15:0] store_mem [STORE_DEPTH];

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   // Bus decode.
   wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr        = wb_req & wb_we_i;
   wire        rd        = wb_req & ~wb_we_i;
   wire        cmd_wr    = wr & (wb_adr_i == A_CMD) & wb_sel_i[0];
   wire        soft_conv = cmd_wr & wb_dat_i[CMD_CONV];
   wire        start_cmd = cmd_wr & wb_dat_i[CMD_START];
   wire        soft_trig = cmd_wr & wb_dat_i[CMD_TRIG];
   wire        list_clr  = cmd_wr & wb_dat_i[CMD_CLEAR];
   wire        abort     = cmd_wr & wb_dat_i[CMD_ABORT];
   wire        list_wr   = wr & (wb_adr_i == A_LIST) & (&wb_sel_i[1:0])
                           & (list_len < 10'(LIST_DEPTH));
   wire        res_rd    = rd & (wb_adr_i == A_RESULT);
   wire        idle      = (phase == PH_IDLE);
   wire        pop       = rd & (wb_adr_i == A_STORE) & idle
                           & (st_cnt != 13'h0000);

   // Timebase: 40 MHz as four ticks in five system clocks.
   // An external timebase above half the system rate loses edges.
   wire [6:0]  tb_sum  = {1'b0, tb_acc} + 7'(INT_TB_MHZ);
   wire        int_tick = (tb_sum >= 7'(SYS_MHZ));
   wire [5:0]  next_tb_acc = int_tick ? 6'(tb_sum - 7'(SYS_MHZ))
                                      : tb_sum[5:0];
   wire        ext_tick = external_pacing_clock_in & ~ext_q;
   wire        tb_tick  = ctrl.ext_tb ? ext_tick : int_tick;
   wire        sclk_tick = tb_tick & (sclk_div == 16'h0000);

   // Trigger source and edge.
   wire        src_lvl = (ctrl.src == TS_ANALOG) ? ana_trig_in
                                                 : dig_trig_in;
   wire        hw_edge = ctrl.trig_fall ? (~src_lvl & src_q)
                                        : (src_lvl & ~src_q);
   wire        trig_ev = (ctrl.src == TS_SOFT) ? soft_trig
                                               : hw_edge;
   wire        m_full  = (pre_scans >= pre_m);
   wire        trig_ok = trig_ev & ((phase == PH_ARMED) |
                         ((phase == PH_PRE) & ~stop_pend &
                          (~ctrl.guard | m_full)));

   // Scan pacing.
   wire        scanning   = (phase == PH_PRE) | (phase == PH_POST);
   wire        post_ok    = (phase == PH_PRE) | (post_left != 24'h0);
   wire        scan_begin = scanning & ~in_scan & ~stop_pend & post_ok
                            & tb_tick & (si_cnt == 24'h0)
                            & (list_len != 10'h000)
                            & (samples_per_scan_count != 9'h000);
   wire        mid_fire   = in_scan & tb_tick & (si2_cnt == 16'h0000)
                            & (samp_left != 10'h000);
   wire        scan_fire  = scan_begin | mid_fire;
   wire        poll_fire  = ~ctrl.scan_mode & idle & soft_conv
                            & (list_len != 10'h000);
   wire        conv_fire  = ctrl.scan_mode ? scan_fire : poll_fire;
   wire        scan_end   = in_scan & adc_done & (res_left == 10'h001);
   wire        st_we      = adc_done & in_scan;
   wire        st_full    = (st_cnt == 13'(STORE_DEPTH));
   wire        drop       = scan_begin & (phase == PH_PRE) & m_full
                            & (st_cnt >= {4'h0, samples_per_scan_count});
   wire [8:0]  list_nxt   = ({1'b0, list_rd} + 10'h001 == list_len)
                            ? 9'h000 : 9'(list_rd + 9'h001);

   wire [31:0] status = {24'h0, ovf, stop_pend, in_scan,
                         2'b00, phase == PH_POST, ~idle, res_ready};
   logic [31:0] rd_mux;
   always_comb begin
      case (wb_adr_i)
         A_CTRL:   rd_mux = ctrl;
         A_STATUS: rd_mux = status;
         A_RESULT: rd_mux = {16'h0, result};
         A_SCAN:   rd_mux = {8'h0, scan_int};
         A_SAMP:   rd_mux = {16'h0, sample_interval_count};
         A_POST:   rd_mux = {8'h0, post_scan_count};
         A_NCHAN:  rd_mux = {23'h0, samples_per_scan_count};
         A_PRE_M:  rd_mux = {16'h0, pre_m};
         A_DELAY:  rd_mux = {16'h0, dly_load};
         A_STCNT:  rd_mux = {19'h0, st_cnt};
         default:  rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= !rd ? 32'h0 : pop ? {16'h0, store_mem[rd_ptr]}
                                        : rd_mux;
      end
   end

   // Configuration registers; each is 24 bits or narrower.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl                   <= CTRL_RST;
         scan_int               <= SCAN_RST;
         sample_interval_count  <= SAMP_RST;
         post_scan_count        <= POST_RST;
         samples_per_scan_count <= NCHAN_RST;
         pre_m                  <= PRE_RST;
         dly_load               <= DELAY_RST;
      end else if (wr) begin
         if (wb_adr_i == A_CTRL)
            ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h1ff;
         if (wb_adr_i == A_SCAN)
            scan_int <= 24'(merge({8'h0, scan_int}, wb_dat_i,
                                  wb_sel_i));
         if (wb_adr_i == A_SAMP)
            sample_interval_count <= 16'(merge({16'h0,
               sample_interval_count}, wb_dat_i, wb_sel_i));
         if (wb_adr_i == A_POST)
            post_scan_count <= 24'(merge({8'h0, post_scan_count},
                                   wb_dat_i, wb_sel_i));
         if (wb_adr_i == A_NCHAN)
            samples_per_scan_count <= 9'(merge({23'h0,
               samples_per_scan_count}, wb_dat_i, wb_sel_i));
         if (wb_adr_i == A_PRE_M)
            pre_m <= 16'(merge({16'h0, pre_m}, wb_dat_i, wb_sel_i));
         if (wb_adr_i == A_DELAY)
            dly_load <= 16'(merge({16'h0, dly_load}, wb_dat_i,
                                  wb_sel_i));
      end
   end

   // Entry list and sample store have no reset.
   always_ff @(posedge sys_clk) begin
      if (list_wr)
         list_mem[list_len[8:0]] <= wb_dat_i[10:0];
      if (st_we && !st_full)
         store_mem[wr_ptr] <= adc_data;
   end

   // Result register, list pointers and conversion strobe.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tb_acc     <= 6'h00;
         ext_q      <= 1'b0;
         src_q      <= 1'b0;
         result     <= 16'h0000;
         res_ready  <= 1'b0;
         list_len   <= 10'h000;
         list_rd    <= 9'h000;
         fire_idx   <= 9'h000;
         conv_start <= 1'b0;
         conv_entry <= 11'h000;
      end else begin
         tb_acc     <= next_tb_acc;
         ext_q      <= external_pacing_clock_in;
         src_q      <= src_lvl;
         conv_start <= conv_fire;
         if (adc_done)
            result <= adc_data;
         res_ready <= adc_done | (res_ready & ~res_rd);
         if (list_clr)
            list_len <= 10'h000;
         else if (list_wr)
            list_len <= 10'(list_len + 10'h001);
         if (list_clr || (start_cmd && idle))
            list_rd <= 9'h000;
         else if (conv_fire) begin
            conv_entry <= list_mem[list_rd];
            fire_idx   <= list_rd;
            list_rd    <= list_nxt;
         end
      end
   end

   // Acquisition phase and scan counters.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase     <= PH_IDLE;
         in_scan   <= 1'b0;
         stop_pend <= 1'b0;
         si_cnt    <= 24'h0;
         si2_cnt   <= 16'h0;
         samp_left <= 10'h000;
         res_left  <= 10'h000;
         post_left <= 24'h0;
         pre_scans <= 16'h0;
         dly_cnt   <= 16'h0;
         sclk_div  <= 16'h0;
      end else begin
         if (tb_tick)
            sclk_div <= sclk_tick ? 16'(sample_interval_count - 16'h1)
                                  : 16'(sclk_div - 16'h1);
         if (scan_begin) begin
            in_scan   <= 1'b1;
            si_cnt    <= 24'(scan_int - 24'h1);
            si2_cnt   <= 16'(sample_interval_count - 16'h1);
            samp_left <= 10'({1'b0, samples_per_scan_count} - 10'h1);
            res_left  <= {1'b0, samples_per_scan_count};
         end else begin
            if (scanning && tb_tick && si_cnt != 24'h0)
               si_cnt <= 24'(si_cnt - 24'h1);
            if (mid_fire) begin
               si2_cnt   <= 16'(sample_interval_count - 16'h1);
               samp_left <= 10'(samp_left - 10'h1);
            end else if (in_scan && tb_tick && si2_cnt != 16'h0)
               si2_cnt <= 16'(si2_cnt - 16'h1);
            if (in_scan && adc_done)
               res_left <= 10'(res_left - 10'h1);
            if (scan_end)
               in_scan <= 1'b0;
         end
         if (scan_end && phase == PH_PRE && !m_full)
            pre_scans <= 16'(pre_scans + 16'h1);
         case (phase)
            PH_IDLE: begin
               if (start_cmd && ctrl.scan_mode) begin
                  si_cnt    <= 24'h0;
                  pre_scans <= 16'h0;
                  stop_pend <= 1'b0;
                  if (ctrl.tmode == TM_PRE || ctrl.tmode == TM_MIDDLE)
                     phase <= PH_PRE;
                  else
                     phase <= PH_ARMED;
               end
            end
            PH_ARMED: begin
               if (trig_ok) begin
                  dly_cnt   <= dly_load;
                  post_left <= post_scan_count;
                  si_cnt    <= 24'h0;
                  phase <= (ctrl.tmode == TM_DELAY) ? PH_DELAY : PH_POST;
               end
            end
            PH_DELAY: begin
               if (dly_cnt == 16'h0)
                  phase <= PH_POST;
               else if (ctrl.dly_sample_clk ? sclk_tick : tb_tick)
                  dly_cnt <= 16'(dly_cnt - 16'h1);
            end
            PH_PRE: begin
               if (trig_ok && ctrl.tmode == TM_MIDDLE) begin
                  phase     <= PH_POST;
                  post_left <= post_scan_count;
               end else if (trig_ok && !in_scan)
                  phase <= PH_IDLE;
               else if (trig_ok)
                  stop_pend <= 1'b1;
               else if (stop_pend && scan_end) begin
                  stop_pend <= 1'b0;
                  phase     <= PH_IDLE;
               end
            end
            PH_POST: begin
               if (scan_end)
                  post_left <= 24'(post_left - 24'h1);
               if ((scan_end && post_left == 24'h1) ||
                   (!in_scan && post_left == 24'h0))
                  phase <= PH_IDLE;
            end
            default: phase <= PH_IDLE;
         endcase
         if (abort) begin
            phase     <= PH_IDLE;
            in_scan   <= 1'b0;
            stop_pend <= 1'b0;
         end
      end
   end

   // Sample store: a ring that forgets its oldest scan in pre-capture.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= 12'h000;
         rd_ptr <= 12'h000;
         st_cnt <= 13'h0000;
         ovf    <= 1'b0;
      end else if (start_cmd && idle) begin
         wr_ptr <= 12'h000;
         rd_ptr <= 12'h000;
         st_cnt <= 13'h0000;
         ovf    <= 1'b0;
      end else begin
         if (st_we && st_full)
            ovf <= 1'b1;
         if (st_we && !st_full)
            wr_ptr <= 12'(wr_ptr + 12'h001);
         if (drop)
            rd_ptr <= 12'(rd_ptr + {3'h0, samples_per_scan_count});
         else if (pop)
            rd_ptr <= 12'(rd_ptr + 12'h001);
         st_cnt <= 13'(st_cnt + {12'h0, st_we & ~st_full}
                   - {12'h0, pop}
                   - (drop ? {4'h0, samples_per_scan_count}
                           : 13'h0000));
      end
   end

   assign simultaneous_hold_out = in_scan;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_scan_open;
      conv_start && simultaneous_hold_out;
   endsequence

   chk_poll_single: assert property (
      conv_start && !$past(ctrl.scan_mode) |-> $past(soft_conv))
      else $error("polling conversion without a command");
   chk_ready_flag: assert property (
      adc_done |=> res_ready && result == $past(adc_data))
      else $error("result not flagged ready");
   chk_entry_order: assert property (
      conv_start |-> conv_entry == list_mem[fire_idx])
      else $error("entry not taken from list pointer");
   chk_list_wrap: assert property (
      conv_fire && !list_clr && {1'b0, list_rd} == list_len - 10'h1
      |=> list_rd == 9'h000)
      else $error("list did not wrap to first entry");
   chk_scan_first: assert property (
      scan_begin |=> s_scan_open ##0 si_cnt == $past(scan_int) - 24'h1)
      else $error("scan start did not convert at once");
   chk_scan_paced: assert property (
      conv_start && $past(ctrl.scan_mode) |-> $past(tb_tick))
      else $error("scan conversion off a timebase tick");
   chk_guard_hold: assert property (
      phase == PH_PRE && ctrl.guard && !m_full && trig_ev && !abort
      && !(stop_pend && scan_end) |=> phase == PH_PRE && !stop_pend)
      else $error("guarded trigger was accepted");
   chk_pre_stop: assert property (
      stop_pend && scan_end && !abort |=> phase == PH_IDLE && !in_scan)
      else $error("pre-trigger stop not at scan end");
   chk_mid_post: assert property (
      phase == PH_PRE && trig_ok && ctrl.tmode == TM_MIDDLE && !abort
      |=> phase == PH_POST && post_left == $past(post_scan_count))
      else $error("middle trigger did not enter post phase");
   chk_delay_end: assert property (
      phase == PH_DELAY && dly_cnt == 16'h0 && !abort
      |=> phase == PH_POST)
      else $error("delay expiry did not start acquisition");
   chk_list_cap: assert property (
      list_len <= 10'(LIST_DEPTH))
      else $error("list length above capacity");
endmodule

// ===== test/ast_conv_model.sv
`timescale 1ns/100ps
// Converter stand-in: answers each start after 2 or 5 cycles, alternately.
module ast_conv_model (
   input  wire logic                sys_clk,
   input  wire logic                arst_n,
   input  wire logic                conv_start,
   input  wire ast_pkg::ast_entry_t conv_entry,
   output logic                     adc_done,
   output logic [15:0]              adc_data
);
   import ast_pkg::*;
   logic       busy, slow;
   logic [2:0] cnt;
   ast_entry_t held;
   // The sample echoes the entry, so a wrong channel shows in the data.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         {busy, slow, cnt, held, adc_done, adc_data} <= '0;
      end else begin
         adc_done <= 1'b0;
         // Data is only valid with done; keep it moving otherwise.
         adc_data <= ~adc_data;
         if (conv_start) begin
            busy <= 1'b1;
            cnt  <= slow ? 3'h4 : 3'h1;
            slow <= !slow;
            held <= conv_entry;
         end else if (busy && cnt == 3'h0) begin
            busy     <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= {5'h1a, held};
         end else if (busy) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
endmodule

// ===== test/ast_sequencer_test.sv
`timescale 1ns/100ps
module ast_sequencer_test;
   import ast_pkg::*;
   logic        sys_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0;
   logic        ana = 0, dig = 0, hold_seen = 0, ack, done, start, hold;
   logic [7:0]  adr = 8'h00;
   logic [1:0]  ediv = 2'b00;
   logic [31:0] wdat = 32'h00000000, rdat, dat_o;
   logic [15:0] data;
   ast_entry_t  entry;
   int          fails = 0, checked = 0, tnow = 0;
   int          tq[$];
   ast_entry_t  seen[$];
   logic [10:0] ent[4] = '{11'h103, 11'h581, 11'h242, 11'h581};
   logic [7:0]  ra[6] = '{A_SCAN, A_SAMP, A_POST, A_NCHAN, A_PRE_M, A_DELAY};
   logic [31:0] rv[6] = '{32'h280, 32'ha0, 32'h1, 32'h1, 32'h1, 32'h0};
   logic [31:0] wv[6] = '{32'hffffff, 32'hffff, 32'hffffff, 32'h1ff,
                          32'hffff, 32'hffff};
   always #10 sys_clk = ~sys_clk;
   // External timebase with one rising edge every four clocks.
   always @(posedge sys_clk) ediv <= ediv + 2'b01;
   always @(posedge sys_clk) begin
      tnow++;
      if (hold === 1'b1) hold_seen = 1'b1;
      if (start === 1'b1) begin
         seen.push_back(entry);
         tq.push_back(tnow);
      end
   end
   ast_sequencer DUT (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .external_pacing_clock_in(ediv[1]), .ana_trig_in(ana),
      .dig_trig_in(dig), .adc_done(done), .adc_data(data),
      .conv_start(start), .conv_entry(entry), .simultaneous_hold_out(hold));
   ast_conv_model conv (.sys_clk(sys_clk), .arst_n(arst_n),
      .conv_start(start), .conv_entry(entry), .adc_done(done),
      .adc_data(data));
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge sys_clk); while (ack !== 1'b1);
      rdat = dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task wait_idle;
      do bus(0, A_STATUS, 0); while (rdat[1] !== 1'b0);
   endtask
   // Configure and start a capture.
   task arm(input logic [31:0] c, p, m);
      bus(1, A_CTRL, c);
      bus(1, A_POST, p);
      bus(1, A_PRE_M, m);
      seen.delete();
      tq.delete();
      bus(1, A_CMD, 32'h2);
   endtask
   // Give one trigger line a single rising edge.
   task pulse(input int gap, input logic use_ana);
      repeat (gap) @(posedge sys_clk);
      if (use_ana) ana <= 1'b1;
      else dig <= 1'b1;
      repeat (3) @(posedge sys_clk);
      {ana, dig} <= 2'b00;
   endtask
   task results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      results;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      bus(0, A_CTRL, 0);
      chk("ctrl reset", rdat, 32'h0);
      bus(0, 8'hfc, 0);
      chk("unmapped", rdat, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(0, ra[i], 0);
         chk("reset value", rdat, rv[i]);
         bus(1, ra[i], '1);
         bus(0, ra[i], 0);
         chk("width", rdat, wv[i]);
      end
      $display("registers done");
      bus(1, A_CMD, 32'h8);
      for (int i = 0; i < 4; i++) bus(1, A_LIST, 32'(ent[i]));
      seen.delete();
      for (int i = 0; i < 10; i++) begin
         bus(1, A_CMD, 32'h1);
         do bus(0, A_STATUS, 0); while (rdat[0] !== 1'b1);
         bus(0, A_RESULT, 0);
         chk("result", rdat, 32'({5'h1a, ent[i % 4]}));
      end
      chk("conversions", 32'(seen.size()), 32'd10);
      bus(0, A_STATUS, 0);
      chk("ready clear", 32'(rdat[0]), 32'h0);
      $display("polling done");
      bus(1, A_CMD, 32'h8);
      bus(1, A_LIST, 32'(ent[0]));
      bus(1, A_LIST, 32'(ent[1]));
      bus(1, A_SAMP, 32'd20);
      bus(1, A_SCAN, 32'd80);
      bus(1, A_NCHAN, 32'd2);
      arm(32'h13, 32'd3, 32'd1);
      pulse(5, 1'b0);
      wait_idle;
      chk("post scans", 32'(seen.size()), 32'd6);
      chk("sample gap", 32'(tq[1] - tq[0]), 32'd25);
      chk("scan gap", 32'(tq[2] - tq[0]), 32'd100);
      chk("wrap", 32'(seen[2]), 32'(ent[0]));
      chk("hold seen", 32'(hold_seen), 32'h1);
      bus(0, A_STCNT, 0);
      chk("post stored", rdat, 32'd6);
      $display("post trigger done");
      arm(32'h53, 32'd3, 32'd1);
      pulse(5, 1'b0);
      wait_idle;
      chk("ext sample gap", 32'(tq[1] - tq[0]), 32'd80);
      chk("ext scans", 32'(seen.size()), 32'd6);
      $display("external timebase done");
      arm(32'h29, 32'd0, 32'd2);
      pulse(0, 1'b1);
      bus(0, A_STATUS, 0);
      chk("guard held", 32'({rdat[6], rdat[1]}), 32'h1);
      pulse(450, 1'b1);
      wait_idle;
      chk("early trigger", 32'(seen.size() > 0), 32'h1);
      bus(0, A_STCNT, 0);
      chk("pre stored", rdat, 32'd4);
      bus(0, A_STORE, 0);
      chk("first stored", rdat, 32'({5'h1a, ent[0]}));
      $display("pre trigger done");
      results;
   end
endmodule
